// [core/bridge_status_pkg.sv]
package bridge_status_pkg;

   // -----------------------------------------------------------------
   // register byte addresses
   // -----------------------------------------------------------------
   localparam logic [31:0] STATUS_OFS = 32'h0000_0000;
   localparam logic [31:0] COMMAND_OFS = 32'h0000_0004;
   localparam logic [31:0] MASK_OFS = 32'h0000_0008;

   // -----------------------------------------------------------------
   // status field positions
   // -----------------------------------------------------------------
   localparam int unsigned POS_UNSUP_CPL = 13;
   localparam int unsigned POS_RX_ABORT = 12;
   localparam int unsigned POS_SIG_ABORT = 11;
   localparam int unsigned POS_SEL_TIMING_HI = 10;
   localparam int unsigned POS_SEL_TIMING_LO = 9;
   localparam int unsigned POS_POISON = 8;
   localparam int unsigned POS_B2B = 7;
   localparam int unsigned POS_RESERVED = 6;
   localparam int unsigned POS_HIGH_SPEED = 5;
   localparam int unsigned POS_EXTRA_CAPABILITIES_PRESENT = 4;
   localparam int unsigned POS_INT_STATUS = 3;

   // -----------------------------------------------------------------
   // command field positions
   // -----------------------------------------------------------------
   localparam int unsigned POS_PARITY_RESP = 6;

   // -----------------------------------------------------------------
   // layouts and values after reset
   // -----------------------------------------------------------------
   localparam logic [15:0] FLAG_MASK = 16'h3900;
   localparam logic [15:0] STATUS_FIXED = 16'h0010;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic PARITY_RESP_RST = 1'b0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // -----------------------------------------------------------------
   // bus slave states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_DONE = 3'b100
   } bus_state_t;

endpackage : bridge_status_pkg

// [core/bridge_primary_status_bits.sv]
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

module bridge_primary_status_bits
   import bridge_status_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic cpl_unsupported_rx,
   input wire logic cpl_abort_rx,
   input wire logic cpl_abort_sent,
   input wire logic cpl_poisoned_rx,
   input wire logic write_poisoned,
   output logic irq
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   bus_state_t state_q, state_d;
   logic [31:0] addr_q, addr_d;
   logic wr_pend_q, wr_pend_d;
   logic [31:0] rdata_q, rdata_d;
   logic [15:0] flags_q, flags_d;
   logic [15:0] mask_q, mask_d;
   logic parity_resp_q, parity_resp_d;
   logic accept;
   logic [15:0] w1c_vec;
   logic [15:0] set_vec;
   logic [15:0] status_word;
   logic [15:0] read_word;

   // -----------------------------------------------------------------
   // bus slave
   // -----------------------------------------------------------------
   // hsize is not checked: only whole-word transfers are expected
   assign accept = hsel & hready & htrans[1];

   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      wr_pend_d = 1'b0;
      rdata_d = rdata_q;
      case (state_q)
         ST_READ: begin
            // one wait state so a write just before is seen
            rdata_d = {16'h0000, read_word};
            state_d = ST_DONE;
         end
         ST_IDLE, ST_DONE: begin
            state_d = ST_IDLE;
            if (accept) begin
               addr_d = haddr;
               wr_pend_d = hwrite;
               if (!hwrite) begin
                  state_d = ST_READ;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         addr_q <= 32'h0000_0000;
         wr_pend_q <= 1'b0;
         rdata_q <= RDATA_RST;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         wr_pend_q <= wr_pend_d;
         rdata_q <= rdata_d;
      end
   end

   assign hreadyout = (state_q != ST_READ);
   assign hrdata = rdata_q;
   assign hresp = 1'b0;

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   always_comb begin
      status_word = STATUS_FIXED | (flags_q & FLAG_MASK);
      status_word[POS_SEL_TIMING_HI] = 1'b0;
      status_word[POS_SEL_TIMING_LO] = 1'b0;
      status_word[POS_B2B] = 1'b0;
      status_word[POS_RESERVED] = 1'b0;
      status_word[POS_HIGH_SPEED] = 1'b0;
      status_word[POS_INT_STATUS] = 1'b0;
   end

   always_comb begin
      read_word = 16'h0000;
      case (addr_q)
         STATUS_OFS: begin
            read_word = status_word;
         end
         COMMAND_OFS: begin
            read_word[POS_PARITY_RESP] = parity_resp_q;
         end
         MASK_OFS: begin
            read_word = mask_q;
         end
         default: begin
            read_word = 16'h0000;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // sticky flags and control
   // -----------------------------------------------------------------
   always_comb begin
      w1c_vec = 16'h0000;
      if (wr_pend_q && addr_q == STATUS_OFS) begin
         w1c_vec = hwdata[15:0] & FLAG_MASK;
      end
   end

   always_comb begin
      set_vec = 16'h0000;
      set_vec[POS_UNSUP_CPL] = cpl_unsupported_rx;
      set_vec[POS_RX_ABORT] = cpl_abort_rx;
      set_vec[POS_SIG_ABORT] = cpl_abort_sent;
      // gated by the enable as it stands when the event arrives
      set_vec[POS_POISON] = parity_resp_q &
         (cpl_poisoned_rx | write_poisoned);
   end

   always_comb begin
      // a set in the clearing cycle wins, so no event is lost
      flags_d = ((flags_q & ~w1c_vec) | set_vec) & FLAG_MASK;
      mask_d = mask_q;
      parity_resp_d = parity_resp_q;
      if (wr_pend_q && addr_q == MASK_OFS) begin
         mask_d = hwdata[15:0] & FLAG_MASK;
      end
      if (wr_pend_q && addr_q == COMMAND_OFS) begin
         parity_resp_d = hwdata[POS_PARITY_RESP];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= STATUS_RST;
         mask_q <= MASK_RST;
         parity_resp_q <= PARITY_RESP_RST;
      end else begin
         flags_q <= flags_d;
         mask_q <= mask_d;
         parity_resp_q <= parity_resp_d;
      end
   end

   // -----------------------------------------------------------------
   // interrupt
   // -----------------------------------------------------------------
   // level output straight from flops, no extra latency
   assign irq = |(flags_q & mask_q);

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence status_read_s;
      state_q == ST_READ && addr_q == STATUS_OFS;
   endsequence

   chk_unsup_sets: assert property (
      cpl_unsupported_rx |=> flags_q[POS_UNSUP_CPL] &&
         (irq || !mask_q[POS_UNSUP_CPL]))
      else $error("unsupported completion did not set its flag");

   chk_rx_abort_sets: assert property (
      cpl_abort_rx |=> flags_q[POS_RX_ABORT])
      else $error("received abort did not set its flag");

   chk_sig_abort_sets: assert property (
      cpl_abort_sent |=> flags_q[POS_SIG_ABORT])
      else $error("signaled abort did not set its flag");

   chk_timing_zero: assert property (
      status_read_s |=> hreadyout && hrdata[10:9] == 2'b00)
      else $error("select timing bits not zero");

   chk_poison_gated: assert property (
      !flags_q[POS_POISON] && !(parity_resp_q &&
         (cpl_poisoned_rx || write_poisoned)) |=> !flags_q[POS_POISON])
      else $error("poison flag set without enabled event");

   chk_poison_sets: assert property (
      parity_resp_q && (cpl_poisoned_rx || write_poisoned)
         |=> flags_q[POS_POISON])
      else $error("enabled poison event did not set flag");

   chk_b2b_zero: assert property (
      status_read_s |=> !hrdata[POS_B2B])
      else $error("back-to-back capable bit not zero");

   chk_reserved_zero: assert property (
      status_read_s ##1 1'b1 |-> !hrdata[POS_RESERVED])
      else $error("reserved status bit not zero");

   chk_speed_zero: assert property (
      status_read_s |=> hrdata[POS_HIGH_SPEED] == 1'b0)
      else $error("high speed capable bit not zero");

   chk_extra_capabilities_present_one: assert property (
      status_read_s |=> hrdata[POS_EXTRA_CAPABILITIES_PRESENT] && hrdata[31:16] == 16'h0000)
      else $error("capabilities list bit not one");

   chk_int_zero: assert property (
      status_read_s |=> !hrdata[POS_INT_STATUS])
      else $error("interrupt status bit not zero");

   chk_flag_holds: assert property (
      flags_q[POS_UNSUP_CPL] && !w1c_vec[POS_UNSUP_CPL]
         |=> flags_q[POS_UNSUP_CPL] [*1])
      else $error("flag dropped without a write of one");

   chk_w1c_clears: assert property (
      w1c_vec[POS_RX_ABORT] && !cpl_abort_rx |=> !flags_q[POS_RX_ABORT])
      else $error("write of one did not clear flag");

   chk_read_wait: assert property (
      accept && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read answer not after one wait state");

   chk_write_no_wait: assert property (
      accept && hwrite |=> hreadyout)
      else $error("write data phase was stretched");

   chk_resp_okay: assert property (
      hresp == 1'b0)
      else $error("slave response not okay");

   chk_irq_follows: assert property (
      flags_q[POS_RX_ABORT] && mask_q[POS_RX_ABORT] |-> irq)
      else $error("unmasked flag did not raise interrupt");

   chk_irq_quiet: assert property (
      mask_q == 16'h0000 |-> !irq)
      else $error("interrupt raised while all masked");

   chk_mask_layout: assert property (
      (mask_q & ~FLAG_MASK) == 16'h0000)
      else $error("mask holds bits outside the flags");

   chk_flag_layout: assert property (
      (flags_q & ~FLAG_MASK) == 16'h0000)
      else $error("status flag outside its positions");

   chk_poison_blocked: assert property (
      !parity_resp_q && !flags_q[POS_POISON] |=> !flags_q[POS_POISON])
      else $error("poison flag set while response disabled");

   chk_read_upper_zero: assert property (
      state_q == ST_READ |=> hrdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   cov_irq_raise: cover property (
      !irq ##1 irq);

   cov_clear_race: cover property (
      w1c_vec[POS_SIG_ABORT] && cpl_abort_sent);

   cov_write_then_read: cover property (
      wr_pend_q && state_d == ST_READ);

   cov_poison_blocked: cover property (
      !parity_resp_q && cpl_poisoned_rx);

endmodule : bridge_primary_status_bits

`default_nettype wire

// [bench/link_partner_model.sv]
`timescale 1ns/100ps
`default_nettype none

module link_partner_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [4:0] ev_req,
   output logic cpl_unsupported_rx,
   output logic cpl_abort_rx,
   output logic cpl_abort_sent,
   output logic cpl_poisoned_rx,
   output logic write_poisoned
);

   // ----------------------------------------------------------------
   // event lines
   // ----------------------------------------------------------------
   // registered so every event line moves just after an edge, never
   // inside the design's sampling window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {cpl_unsupported_rx, cpl_abort_rx, cpl_abort_sent,
          cpl_poisoned_rx, write_poisoned} <= 5'h00;
      end else begin
         {cpl_unsupported_rx, cpl_abort_rx, cpl_abort_sent,
          cpl_poisoned_rx, write_poisoned} <= ev_req;
      end
   end

endmodule : link_partner_model

`default_nettype wire

// [bench/bridge_primary_status_bits_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module bridge_primary_status_bits_tb;
   import bridge_status_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] ev_req;
   logic unsup, ab_rx, ab_sent, pois_rx, wr_pois;
   logic [15:0] ev_bit [5] = '{16'h0100, 16'h0100, 16'h0800,
                                16'h1000, 16'h2000};
   int err_count, checks_done, cycles;

   assign hready = hreadyout;

   bridge_primary_status_bits dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .cpl_unsupported_rx(unsup), .cpl_abort_rx(ab_rx),
      .cpl_abort_sent(ab_sent), .cpl_poisoned_rx(pois_rx),
      .write_poisoned(wr_pois), .irq(irq));

   link_partner_model partner (.hclk(hclk), .hresetn(hresetn),
      .ev_req(ev_req), .cpl_unsupported_rx(unsup), .cpl_abort_rx(ab_rx),
      .cpl_abort_sent(ab_sent), .cpl_poisoned_rx(pois_rx),
      .write_poisoned(wr_pois));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic rdchk(input string name, input logic [31:0] a,
                        input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(name, exp, rd);
   endtask : rdchk

   // one-cycle event from the link, flag settled on return
   task automatic pulse(input int i);
      ev_req <= 5'h01 << i;
      @(posedge hclk);
      ev_req <= 5'h00;
      repeat (2) @(posedge hclk);
   endtask : pulse

   task automatic test_done();
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------
   // clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // whole run needs well under a thousand cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, ev_req} = '0;
      hsize = 3'b010;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk("status reset", STATUS_OFS, 32'h0000_0010);
      rdchk("mask reset", MASK_OFS, 32'h0000_0000);
      rdchk("command reset", COMMAND_OFS, 32'h0000_0000);
      chk("okay response", 32'h0000_0000, {31'h0000_0000, hresp});
      bus(1'b1, STATUS_OFS, 32'hffff_ffff);
      rdchk("status fixed", STATUS_OFS, 32'h0000_0010);
      rdchk("fixed bits", STATUS_OFS, 32'h0000_0010);
      rdchk("int status", STATUS_OFS, 32'h0000_0010);
      for (int i = 0; i < 2; i++) begin
         pulse(i);
         rdchk("poison gated", STATUS_OFS, 32'h0000_0010);
      end
      bus(1'b1, COMMAND_OFS, 32'h0000_ffff);
      rdchk("command", COMMAND_OFS, 32'h0000_0040);
      bus(1'b1, MASK_OFS, 32'hffff_ffff);
      rdchk("mask", MASK_OFS, 32'h0000_3900);
      for (int i = 0; i < 5; i++) begin
         pulse(i);
         rdchk("flag set", STATUS_OFS, {16'h0000, 16'h0010 | ev_bit[i]});
         chk("irq on", 32'h0000_0001, {31'h0000_0000, irq});
         bus(1'b1, STATUS_OFS, {16'h0000, ~ev_bit[i]});
         rdchk("flag kept", STATUS_OFS, {16'h0000, 16'h0010 | ev_bit[i]});
         bus(1'b1, STATUS_OFS, {16'h0000, ev_bit[i]});
         rdchk("flag cleared", STATUS_OFS, 32'h0000_0010);
         chk("irq off", 32'h0000_0000, {31'h0000_0000, irq});
      end
      bus(1'b1, MASK_OFS, 32'h0000_0000);
      pulse(3);
      rdchk("masked flag", STATUS_OFS, 32'h0000_1010);
      chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
      bus(1'b1, 32'h0000_0010, 32'hffff_ffff);
      rdchk("unmapped", 32'h0000_0010, 32'h0000_0000);
      rdchk("after unmapped", STATUS_OFS, 32'h0000_1010);
      // second reset in mid-run must drop the sticky flag
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk("status after reset", STATUS_OFS, 32'h0000_0010);
      rdchk("command after reset", COMMAND_OFS, 32'h0000_0000);
      chk("irq after reset", 32'h0000_0000, {31'h0000_0000, irq});
      test_done();
   end

endmodule : bridge_primary_status_bits_tb

`default_nettype wire
